// *** hw/gpn_defines.svh ***
// Purpose: Register indices, reset values and field layout of the port block
// Assumes: Byte address on the bus is four times the index, plus the op field
// Notes:   Definitions only
`ifndef GPN_DEFINES_SVH
`define GPN_DEFINES_SVH

// Register indices
`define GPN_IDX_LATCH0   16'hFF00
`define GPN_IDX_LATCH6   16'hFF06
`define GPN_IDX_LATCH7   16'hFF07
`define GPN_IDX_LATCH8   16'hFF08
`define GPN_IDX_LATCH9   16'hFF09
`define GPN_IDX_DIR0     16'hFF20
`define GPN_IDX_DIR6     16'hFF26
`define GPN_IDX_DIR7     16'hFF27
`define GPN_IDX_DIR8     16'hFF28
`define GPN_IDX_DIR9     16'hFF29
`define GPN_IDX_PU6      16'hFF36
`define GPN_IDX_PU7      16'hFF37
`define GPN_IDX_PU8      16'hFF38
`define GPN_IDX_PU9      16'hFF39
`define GPN_IDX_SEG7     16'hFF3A
`define GPN_IDX_SEG8     16'hFF3B
`define GPN_IDX_SEG9     16'hFF3C

// Address fields
`define GPN_IDX_MSB      17
`define GPN_IDX_LSB      2
`define GPN_OP_MSB       19
`define GPN_OP_LSB       18

// Reset values
`define GPN_DIR_RST      8'hFF
`define GPN_PU_RST       8'h00
`define GPN_LATCH_RST    8'h00
`define GPN_SEG_RST      1'h0

// Implemented bits
`define GPN_P0_MASK      8'h7F
`define GPN_P9_MASK      8'h3F
`define GPN_PU6_MASK     8'hF8
`define GPN_OD_MASK      8'h07
`define GPN_ALL_ONES     8'hFF
`define GPN_RT_LSB       3

`endif

// *** hw/gpn_pkg.sv ***
// Purpose: Types shared by the port block and its users
// Assumes: Nothing beyond the defines header
// Notes:   Pad bundles carry level, enable and pull-up per pin
package gpn_pkg;

    typedef enum logic [1:0] {
        GPN_OP_WRITE,
        GPN_OP_SET,
        GPN_OP_CLEAR,
        GPN_OP_NONE
    } gpn_op_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } gpn_pad_t;

    // Bit 0 is the enable output, bits 1 to 4 the four real-time outputs
    typedef struct packed {
        logic [4:0] active;
        logic [4:0] level;
    } gpn_rt_t;

endpackage : gpn_pkg

// *** hw/gpn_ports.sv ***
// Purpose: Ports zero, six, seven, eight and nine behind an Avalon-MM slave
// Assumes: Pin inputs synchronous to clock; byte address bits 19:18 select the op
// Notes:   Op 1 sets and op 2 clears the bits that are one in the write data
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`include "gpn_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module gpn_ports #(
    parameter logic [2:0] OD_PULLUP = 3'h0
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // Avalon-MM slave
    input  wire logic [19:0]      avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [3:0]       avs_byteenable,
    input  wire logic [31:0]      avs_writedata,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    // Pins
    input  wire logic [7:0]       p0_in,
    input  wire logic [7:0]       p6_in,
    input  wire logic [7:0]       p7_in,
    input  wire logic [7:0]       p8_in,
    input  wire logic [7:0]       p9_in,
    output gpn_pkg::gpn_pad_t     p0_pad,
    output gpn_pkg::gpn_pad_t     p6_pad,
    output gpn_pkg::gpn_pad_t     p7_pad,
    output gpn_pkg::gpn_pad_t     p8_pad,
    output gpn_pkg::gpn_pad_t     p9_pad,
    // Alternate functions
    input  wire gpn_pkg::gpn_rt_t rt,
    input  wire logic [7:0]       segment_group_a,
    input  wire logic [7:0]       segment_group_b,
    input  wire logic [5:0]       segment_group_c,
    // Interrupt request set pulses for port zero
    output logic [6:0]            p0_irq_set
);

    logic [7:0]       latch0_ff, latch6_ff, latch7_ff, latch8_ff, latch9_ff;
    logic [7:0]       port0_direction_reg, port6_direction_reg, port7_direction_reg;
    logic [7:0]       port8_direction_reg, port9_direction_reg;
    logic [7:0]       port6_pullup_select, port7_pullup_select;
    logic [7:0]       port8_pullup_select, port9_pullup_select;
    logic             port7_segment_select, port8_segment_select, port9_segment_select;
    logic [7:0]       prev0_ff;
    logic             ack_ff;
    logic [31:0]      rdata_ff;
    logic [15:0]      idx;
    gpn_pkg::gpn_op_t op;
    logic             wr_go;
    logic [7:0]       wdat;
    logic [7:0]       rd_byte;
    logic [7:0]       rd0, rd6, rd7, rd8, rd9;
    logic [7:0]       lvl6;
    logic [7:0]       alt6;
    logic [7:0]       nxt_seg7, nxt_seg8, nxt_seg9;

    function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] d,
                                       input gpn_pkg::gpn_op_t o);
        case (o)
            gpn_pkg::GPN_OP_SET:   upd = old | d;
            gpn_pkg::GPN_OP_CLEAR: upd = old & ~d;
            default:               upd = d;
        endcase
    endfunction : upd

    // Bus decode; one wait cycle gives every access a fixed two-cycle shape
    assign idx             = avs_address[`GPN_IDX_MSB:`GPN_IDX_LSB];
    assign op              = gpn_pkg::gpn_op_t'(avs_address[`GPN_OP_MSB:`GPN_OP_LSB]);
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_go           = avs_write & ack_ff & avs_byteenable[0]
                             & (op != gpn_pkg::GPN_OP_NONE);
    assign wdat            = avs_writedata[7:0];
    assign avs_readdata    = rdata_ff;
    assign nxt_seg7        = upd({7'h00, port7_segment_select}, wdat, op);
    assign nxt_seg8        = upd({7'h00, port8_segment_select}, wdat, op);
    assign nxt_seg9        = upd({7'h00, port9_segment_select}, wdat, op);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
        end
    end

    // Output latches
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            latch0_ff <= `GPN_LATCH_RST;
            latch6_ff <= `GPN_LATCH_RST;
            latch7_ff <= `GPN_LATCH_RST;
            latch8_ff <= `GPN_LATCH_RST;
            latch9_ff <= `GPN_LATCH_RST;
        end else if (wr_go) begin
            case (idx)
                `GPN_IDX_LATCH0: latch0_ff <= upd(latch0_ff, wdat, op) & `GPN_P0_MASK;
                `GPN_IDX_LATCH6: latch6_ff <= upd(latch6_ff, wdat, op);
                `GPN_IDX_LATCH7: latch7_ff <= upd(latch7_ff, wdat, op);
                `GPN_IDX_LATCH8: latch8_ff <= upd(latch8_ff, wdat, op);
                `GPN_IDX_LATCH9: latch9_ff <= upd(latch9_ff, wdat, op) & `GPN_P9_MASK;
                default: ;
            endcase
        end
    end

    // Direction registers; missing bits of ports zero and nine read as one
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port0_direction_reg <= `GPN_DIR_RST;
            port6_direction_reg <= `GPN_DIR_RST;
            port7_direction_reg <= `GPN_DIR_RST;
            port8_direction_reg <= `GPN_DIR_RST;
            port9_direction_reg <= `GPN_DIR_RST;
        end else if (wr_go) begin
            case (idx)
                `GPN_IDX_DIR0: port0_direction_reg <= upd(port0_direction_reg, wdat, op)
                                                      | ~`GPN_P0_MASK;
                `GPN_IDX_DIR6: port6_direction_reg <= upd(port6_direction_reg, wdat, op);
                `GPN_IDX_DIR7: port7_direction_reg <= upd(port7_direction_reg, wdat, op);
                `GPN_IDX_DIR8: port8_direction_reg <= upd(port8_direction_reg, wdat, op);
                `GPN_IDX_DIR9: port9_direction_reg <= upd(port9_direction_reg, wdat, op)
                                                      | ~`GPN_P9_MASK;
                default: ;
            endcase
        end
    end

    // Pull-up option registers; the lower three port-six bits do not exist here
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port6_pullup_select <= `GPN_PU_RST;
            port7_pullup_select <= `GPN_PU_RST;
            port8_pullup_select <= `GPN_PU_RST;
            port9_pullup_select <= `GPN_PU_RST;
        end else if (wr_go) begin
            case (idx)
                `GPN_IDX_PU6: port6_pullup_select <= upd(port6_pullup_select, wdat, op)
                                                     & `GPN_PU6_MASK;
                `GPN_IDX_PU7: port7_pullup_select <= upd(port7_pullup_select, wdat, op);
                `GPN_IDX_PU8: port8_pullup_select <= upd(port8_pullup_select, wdat, op);
                `GPN_IDX_PU9: port9_pullup_select <= upd(port9_pullup_select, wdat, op)
                                                     & `GPN_P9_MASK;
                default: ;
            endcase
        end
    end

    // Segment selects use bit 0 of the data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port7_segment_select <= `GPN_SEG_RST;
            port8_segment_select <= `GPN_SEG_RST;
            port9_segment_select <= `GPN_SEG_RST;
        end else if (wr_go) begin
            case (idx)
                `GPN_IDX_SEG7: port7_segment_select <= nxt_seg7[0];
                `GPN_IDX_SEG8: port8_segment_select <= nxt_seg8[0];
                `GPN_IDX_SEG9: port9_segment_select <= nxt_seg9[0];
                default: ;
            endcase
        end
    end

    // Port reads pick pin or latch per bit
    assign rd0 = ((port0_direction_reg & p0_in) | (~port0_direction_reg & latch0_ff))
                 & `GPN_P0_MASK;
    assign rd6 = (port6_direction_reg & p6_in) | (~port6_direction_reg & latch6_ff);
    assign rd7 = (port7_direction_reg & p7_in) | (~port7_direction_reg & latch7_ff);
    assign rd8 = (port8_direction_reg & p8_in) | (~port8_direction_reg & latch8_ff);
    assign rd9 = ((port9_direction_reg & p9_in) | (~port9_direction_reg & latch9_ff))
                 & `GPN_P9_MASK;

    always_comb begin
        case (idx)
            `GPN_IDX_LATCH0: rd_byte = rd0;
            `GPN_IDX_LATCH6: rd_byte = rd6;
            `GPN_IDX_LATCH7: rd_byte = rd7;
            `GPN_IDX_LATCH8: rd_byte = rd8;
            `GPN_IDX_LATCH9: rd_byte = rd9;
            `GPN_IDX_DIR0:   rd_byte = port0_direction_reg;
            `GPN_IDX_DIR6:   rd_byte = port6_direction_reg;
            `GPN_IDX_DIR7:   rd_byte = port7_direction_reg;
            `GPN_IDX_DIR8:   rd_byte = port8_direction_reg;
            `GPN_IDX_DIR9:   rd_byte = port9_direction_reg;
            `GPN_IDX_PU6:    rd_byte = port6_pullup_select;
            `GPN_IDX_PU7:    rd_byte = port7_pullup_select;
            `GPN_IDX_PU8:    rd_byte = port8_pullup_select;
            `GPN_IDX_PU9:    rd_byte = port9_pullup_select;
            `GPN_IDX_SEG7:   rd_byte = {7'h00, port7_segment_select};
            `GPN_IDX_SEG8:   rd_byte = {7'h00, port8_segment_select};
            `GPN_IDX_SEG9:   rd_byte = {7'h00, port9_segment_select};
            default:         rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 32'h00000000;
        end else if (avs_read & ~ack_ff) begin
            rdata_ff <= (op == gpn_pkg::GPN_OP_WRITE) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Port zero pins double as interrupt inputs, so a driven change is seen
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev0_ff <= `GPN_LATCH_RST;
        end else begin
            prev0_ff <= latch0_ff;
        end
    end

    assign p0_irq_set = ~port0_direction_reg[6:0] & (latch0_ff[6:0] ^ prev0_ff[6:0]);
    assign p0_pad.out = latch0_ff;
    assign p0_pad.oe  = ~port0_direction_reg;
    assign p0_pad.pu  = `GPN_PU_RST;

    // Port six: real-time outputs are ORed with the latch, which must be zero
    assign alt6 = {rt.level & rt.active, 3'h0};
    assign lvl6 = latch6_ff | alt6;
    assign p6_pad.out = lvl6 & ~`GPN_OD_MASK;
    assign p6_pad.oe  = ~port6_direction_reg & (~`GPN_OD_MASK | ~lvl6);
    assign p6_pad.pu  = port6_pullup_select | {5'h00, OD_PULLUP};

    // Segment mode overrides direction and latch entirely
    assign p7_pad.out = port7_segment_select ? segment_group_a : latch7_ff;
    assign p7_pad.oe  = port7_segment_select ? `GPN_ALL_ONES : ~port7_direction_reg;
    assign p7_pad.pu  = port7_pullup_select;
    assign p8_pad.out = port8_segment_select ? segment_group_b : latch8_ff;
    assign p8_pad.oe  = port8_segment_select ? `GPN_ALL_ONES : ~port8_direction_reg;
    assign p8_pad.pu  = port8_pullup_select;
    assign p9_pad.out = port9_segment_select ? {2'h0, segment_group_c} : latch9_ff;
    assign p9_pad.oe  = (port9_segment_select ? `GPN_ALL_ONES : ~port9_direction_reg)
                        & `GPN_P9_MASK;
    assign p9_pad.pu  = port9_pullup_select;

    // Helper for the reset check
    logic first_ff;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            first_ff <= 1'b0;
        end else begin
            first_ff <= 1'b1;
        end
    end

    sequence s_wr(logic [15:0] x, gpn_pkg::gpn_op_t o);
        avs_write && !avs_waitrequest && avs_byteenable[0] && idx == x && op == o;
    endsequence

    property p_reset_state;
        @(posedge clock) disable iff (!arst_n)
        !first_ff |-> (p6_pad.oe == 8'h00 && p7_pad.oe == 8'h00 && p8_pad.oe == 8'h00
                       && p9_pad.oe == 8'h00 && p6_pad.pu == {5'h00, OD_PULLUP});
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("ports not idle after reset");

    property p_open_drain;
        @(posedge clock) disable iff (!arst_n)
        (p6_pad.out[2:0] == 3'h0)
        && (p6_pad.oe[2:0] == (~port6_direction_reg[2:0] & ~latch6_ff[2:0]));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain pin drove high");

    property p_seg7;
        @(posedge clock) disable iff (!arst_n)
        s_wr(`GPN_IDX_SEG7, gpn_pkg::GPN_OP_WRITE) ##0 avs_writedata[0]
        |=> (p7_pad.oe == 8'hFF && p7_pad.out == segment_group_a);
    endproperty
    a_seg7: assert property (p_seg7) else $error("port seven not in segment mode");

    property p_seg9;
        @(posedge clock) disable iff (!arst_n)
        port9_segment_select |-> (p9_pad.oe == 8'h3F && p9_pad.out[5:0] == segment_group_c);
    endproperty
    a_seg9: assert property (p_seg9) else $error("port nine segment drive wrong");

    property p_pullup_write;
        @(posedge clock) disable iff (!arst_n)
        s_wr(`GPN_IDX_PU7, gpn_pkg::GPN_OP_WRITE) |=> p7_pad.pu == $past(avs_writedata[7:0]);
    endproperty
    a_pullup_write: assert property (p_pullup_write) else $error("pull-up not applied");

    property p_bit_set;
        @(posedge clock) disable iff (!arst_n)
        s_wr(`GPN_IDX_DIR6, gpn_pkg::GPN_OP_SET)
        |=> port6_direction_reg == ($past(port6_direction_reg) | $past(avs_writedata[7:0]));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set on direction failed");

    property p_answer;
        @(posedge clock) disable iff (!arst_n)
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer not after one wait");

    property p_irq;
        @(posedge clock) disable iff (!arst_n)
        s_wr(`GPN_IDX_LATCH0, gpn_pkg::GPN_OP_WRITE)
        ##0 (((avs_writedata[6:0] ^ latch0_ff[6:0]) & ~port0_direction_reg[6:0]) != 7'h00)
        |=> p0_irq_set != 7'h00 ##1 p0_irq_set == 7'h00;
    endproperty
    a_irq: assert property (p_irq) else $error("port zero change gave no request");

    property p_read6;
        @(posedge clock) disable iff (!arst_n)
        avs_read && !avs_waitrequest && idx == `GPN_IDX_LATCH6 && op == gpn_pkg::GPN_OP_WRITE
        |-> avs_readdata[7:0] == $past(rd6);
    endproperty
    a_read6: assert property (p_read6) else $error("port six read mismatch");

endmodule : gpn_ports

`default_nettype wire

// *** bench/gpn_pin_model.sv ***
// Purpose: Far side of the port pins: outside drivers, pull-ups, floating pins
// Assumes: Chip drivers win over outside drivers on a pin
// Notes:   A floating pin without pull-up toggles so no stale level can be read
`timescale 1ns/1ps
`default_nettype none

module gpn_pin_model (
    // Clock
    input  wire logic                    clock,
    // Chip pads: 0 is port zero, 1 to 4 are ports six to nine
    input  wire gpn_pkg::gpn_pad_t [4:0] pad,
    // Outside drivers
    input  wire logic [4:0][7:0]         ext_en,
    input  wire logic [4:0][7:0]         ext_val,
    // Levels seen by the chip
    output logic [4:0][7:0]              pin_lvl
);
    logic flt_ff = 1'b0;

    always_ff @(posedge clock) begin
        flt_ff <= ~flt_ff;
    end

    always_comb begin
        for (int p = 0; p < 5; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (pad[p].oe[b])
                    pin_lvl[p][b] = pad[p].out[b];
                else if (ext_en[p][b])
                    pin_lvl[p][b] = ext_val[p][b];
                else if (pad[p].pu[b])
                    pin_lvl[p][b] = 1'b1;
                else
                    pin_lvl[p][b] = flt_ff ^ b[0];
            end
        end
    end
endmodule : gpn_pin_model

`default_nettype wire

// *** bench/tb.sv ***
// Purpose: Self-checking bench for ports zero and six to nine
// Assumes: One wait cycle per access, pads combinational from registers
// Notes:   Port nine upper two pad bits are expected low in every mode
`include "gpn_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [2:0] OD_PU = 3'h5;
    logic                     clock;
    logic                     arst_n;
    logic [19:0]              avs_address;
    logic                     avs_read;
    logic                     avs_write;
    logic [31:0]              avs_writedata;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    gpn_pkg::gpn_pad_t        p0_pad, p6_pad, p7_pad, p8_pad, p9_pad;
    gpn_pkg::gpn_pad_t [4:0]  pads;
    gpn_pkg::gpn_rt_t         rt;
    logic [7:0]               seg_a, seg_b, msk, segv;
    logic [5:0]               seg_c;
    logic [6:0]               p0_irq_set;
    logic [6:0]               irq_acc = 7'h00;
    logic [4:0][7:0]          ext_en, ext_val, pin_lvl;
    int                       fail_count = 0;
    int                       total_checks = 0;

    assign pads = {p9_pad, p8_pad, p7_pad, p6_pad, p0_pad};

    gpn_ports #(.OD_PULLUP(OD_PU)) gpn_ports_inst (
        .clock(clock), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .p0_in(pin_lvl[0]), .p6_in(pin_lvl[1]),
        .p7_in(pin_lvl[2]), .p8_in(pin_lvl[3]), .p9_in(pin_lvl[4]),
        .p0_pad(p0_pad), .p6_pad(p6_pad), .p7_pad(p7_pad), .p8_pad(p8_pad),
        .p9_pad(p9_pad), .rt(rt), .segment_group_a(seg_a),
        .segment_group_b(seg_b), .segment_group_c(seg_c), .p0_irq_set(p0_irq_set));

    gpn_pin_model gpn_pin_model_inst (
        .clock(clock), .pad(pads), .ext_en(ext_en), .ext_val(ext_val),
        .pin_lvl(pin_lvl));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (!arst_n) begin
            irq_acc <= 7'h00;
        end else begin
            irq_acc <= irq_acc | p0_irq_set;
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Waitrequest is read at the rising edge, before that edge's updates land
    task automatic wait_ack;
        int n;
        n = 0;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n >= 20) begin
            fail_count++;
            wrap_up();
        end
    endtask : wait_ack

    task automatic wr(input logic [1:0] op, input logic [15:0] idx, input logic [7:0] d);
        avs_address <= {op, idx, 2'h0};
        avs_writedata <= {24'h0, d};
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rdchk(input string nm, input logic [15:0] idx, input logic [7:0] exp);
        avs_address <= {2'h0, idx, 2'h0};
        avs_read <= 1'b1;
        wait_ack();
        chk(nm, avs_readdata, {24'h0, exp});
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : rdchk

    task automatic padchk(input int p, input logic [23:0] exp, input string nm);
        @(negedge clock);
        chk(nm, {8'h0, pads[p]}, {8'h0, exp});
        @(posedge clock);
    endtask : padchk

    initial begin
        arst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        rt = '0;
        seg_a = 8'h5A;
        seg_b = 8'hC3;
        seg_c = 6'h2D;
        ext_en = '0;
        ext_val = '0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        padchk(1, {16'h0000, 5'h00, OD_PU}, "p6 reset pad");
        for (int i = 6; i < 10; i++) begin
            if (i > 6) padchk(i - 5, 24'h000000, "reset pad");
            rdchk("dir reset", 16'(16'hFF20 + i), 8'hFF);
            rdchk("pullup reset", 16'(16'hFF30 + i), 8'h00);
        end
        ext_en[1] <= 8'hFF;
        ext_val[1] <= 8'h3C;
        wr(2'h0, `GPN_IDX_LATCH6, 8'hA5);
        wr(2'h0, `GPN_IDX_DIR6, 8'h00);
        padchk(1, {8'hA0, 8'hFA, 8'h05}, "p6 drive");
        wr(2'h1, `GPN_IDX_DIR6, 8'hF0);
        wr(2'h2, `GPN_IDX_DIR6, 8'h30);
        wr(2'h3, `GPN_IDX_DIR6, 8'hFF);
        rdchk("dir6 bit ops", `GPN_IDX_DIR6, 8'hC0);
        rdchk("port6 read", `GPN_IDX_LATCH6, 8'h25);
        wr(2'h0, `GPN_IDX_PU6, 8'hFF);
        rdchk("pu6", `GPN_IDX_PU6, 8'hF8);
        padchk(1, {8'hA0, 8'h3A, 8'hFD}, "p6 pullup");
        wr(2'h0, `GPN_IDX_PU6, 8'h00);
        wr(2'h0, `GPN_IDX_LATCH6, 8'h00);
        wr(2'h0, `GPN_IDX_DIR6, 8'h00);
        rt <= {5'h0A, 5'h1F};
        padchk(1, {8'h50, 8'hFF, 8'h05}, "p6 realtime");
        rt <= '0;
        for (int i = 7; i < 10; i++) begin
            msk = (i == 9) ? 8'h3F : 8'hFF;
            segv = (i == 7) ? seg_a : (i == 8) ? seg_b : {2'h0, seg_c};
            wr(2'h0, 16'(16'hFF00 + i), 8'h96);
            wr(2'h0, 16'(16'hFF20 + i), 8'h00);
            padchk(i - 5, {8'h96 & msk, msk, 8'h00}, "gpio drive");
            wr(2'h0, 16'(16'hFF20 + i), 8'hFF);
            wr(2'h0, 16'(16'hFF30 + i), 8'h00);
            wr(2'h0, 16'(16'hFF33 + i), 8'h01);
            padchk(i - 5, {segv, msk, 8'h00}, "segment drive");
        end
        wr(2'h0, `GPN_IDX_LATCH0, 8'h02);
        wr(2'h0, `GPN_IDX_DIR0, 8'h00);
        wr(2'h0, `GPN_IDX_LATCH0, 8'h43);
        @(negedge clock);
        chk("irq set", {25'h0, irq_acc}, {25'h0, 7'h41});
        padchk(0, {8'h43, 8'h7F, 8'h00}, "p0 drive");
        wr(2'h0, 16'hFF50, 8'hFF);
        rdchk("unmapped", 16'hFF50, 8'h00);
        wrap_up();
    end
endmodule : tb

`default_nettype wire
